/* src/svwd_pkg.sv */
package svwd_pkg;
   // Clock rate
   localparam int unsigned CLK_PERIOD_NS = 50;
   // Internal timebase of one millisecond
   localparam int unsigned TICK_PERIOD_NS = 1000000;
   localparam int unsigned TICK_CYCLES_NOM = TICK_PERIOD_NS / CLK_PERIOD_NS;
   // Reset pulse: 140 ms min, 200 ms nominal, 280 ms max
   localparam int unsigned RESET_PULSE_MIN_MS = 140;
   localparam int unsigned RESET_PULSE_MAX_MS = 280;
   localparam logic [7:0] RESET_PULSE_MS = 8'hc8;
   // Watchdog timeout: 1.00 s min, 1.60 s nominal, 2.25 s max
   localparam int unsigned WD_TIMEOUT_MIN_MS = 1000;
   localparam int unsigned WD_TIMEOUT_MAX_MS = 2250;
   localparam logic [10:0] WD_TIMEOUT_MS = 11'h640;
   // Shortest kick level the block sees, and manual reset timing
   localparam int unsigned KICK_MIN_WIDTH_NS = 50;
   localparam int unsigned KICK_MIN_WIDTH_CYC =
      (KICK_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MANUAL_PULSE_MIN_WIDTH_LO_NS = 500;
   localparam int unsigned MANUAL_PULSE_MIN_WIDTH_HI_NS = 150;
   localparam int unsigned MANUAL_DELAY_LO_NS = 750;
   localparam int unsigned MANUAL_DELAY_HI_NS = 250;
   localparam int unsigned MANUAL_DELAY_CYC = MANUAL_DELAY_HI_NS / CLK_PERIOD_NS;
   // Reset pulse generator states
   typedef enum logic [1:0] {
      SVWD_RS_HOLD = 2'h0,
      SVWD_RS_TIMING = 2'h1,
      SVWD_RS_RUN = 2'h3
   } svwd_rst_state_t;
endpackage

/* src/svwd_tick.sv */
`timescale 1ns/1ps
module svwd_tick #(
   parameter int unsigned TICK_CYCLES = 20000
) (
   input wire logic clk_i,        // System clock
   input wire logic reset_n_i,    // Asynchronous reset, active low
   output logic tick_o            // One-cycle timebase enable
);
   localparam int unsigned TW = $clog2(TICK_CYCLES + 1);
   localparam logic [TW-1:0] LAST = TW'(TICK_CYCLES - 1);

   logic [TW-1:0] count;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count <= '0;
         tick_o <= 1'b0;
      end else if (count == LAST) begin
         count <= '0;
         tick_o <= 1'b1;
      end else begin
         count <= count + TW'(1);
         tick_o <= 1'b0;
      end
   end
endmodule

/* src/svwd_top.sv */
// Function
// - Manual reset input low starts a reset pulse; floating input counts as high.
// - A triggered reset drives the active-low reset output low for about 200 ms.
// - Reset output stays low while the supply-low indication is active.
// - Reset stays low 200 ms more after supply recovers or manual reset releases.
// - Watchdog expiry never asserts reset by itself; only via external loop.
// - Kick input constant for 1.6 s expires the watchdog, output goes low.
// - Floating kick input disables the watchdog.
// - Watchdog count clears on reset, on floating kick, and on each kick edge.
// - Expired watchdog output stays low until the watchdog is cleared.
// - Watchdog output is low while supply is low, whatever the count.
// - Low-supply watchdog low has no minimum width; releases at once.
// - Complement variant drives active-high reset as exact inverse of reset.
// - Power-fail warning low while sense input is below reference, else high.
// - Reset pulse lies between 140 ms and 280 ms, nominal 200 ms.
// - Watchdog timeout lies between 1.00 s and 2.25 s, nominal 1.60 s.
// - Kick levels of 50 ns are seen; host holds each level that long.
// - Reset asserts within 750 ns or 250 ns of manual reset going low.
// - Complement variant has no watchdog; active-high reset in its place.
`timescale 1ns/1ps
module svwd_top
   import svwd_pkg::*;
#(
   parameter bit HAS_COMPLEMENT = 1'b0,
   parameter int unsigned TICK_CYCLES = TICK_CYCLES_NOM
) (
   input wire logic clk_i,                       // System clock, 20 MHz
   input wire logic reset_n_i,                   // Asynchronous reset, active low
   input wire logic supply_low_i,                // Supply below reset threshold
   input wire logic manual_reset_button_n_i,     // Manual reset level, active low
   input wire logic manual_reset_float_i,        // Manual reset pin undriven
   input wire logic watchdog_kick_in_i,          // Watchdog kick level
   input wire logic watchdog_kick_float_i,       // Kick pin tri-stated
   input wire logic power_fail_sense_in_low_i,   // Comparator: sense below reference
   output logic reset_n_o,                       // Processor reset, active low
   output logic reset_o,                         // Processor reset, active high
   output logic watchdog_expired_n_o,            // Watchdog / low-line, active low
   output logic power_fail_warning_n_o           // Power-fail warning, active low
);
   svwd_rst_state_t rst_state;
   svwd_rst_state_t next_rst_state;
   logic [7:0] rst_count;
   logic tick;
   logic manual_low;
   logic hold;
   logic kick_prev;
   logic kick_edge;
   logic [10:0] wd_count;
   logic wd_clear;
   logic wd_expired;
   logic wd_enable;

   svwd_tick #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .tick_o(tick)
   );

   assign manual_low = !manual_reset_float_i && !manual_reset_button_n_i;
   assign hold = supply_low_i || manual_low;

   always_comb begin
      next_rst_state = rst_state;
      unique case (rst_state)
         SVWD_RS_HOLD: begin
            if (!hold) begin
               next_rst_state = SVWD_RS_TIMING;
            end
         end
         SVWD_RS_TIMING: begin
            if (hold) begin
               next_rst_state = SVWD_RS_HOLD;
            end else if (tick && rst_count == 8'h01) begin
               next_rst_state = SVWD_RS_RUN;
            end
         end
         SVWD_RS_RUN: begin
            if (hold) begin
               next_rst_state = SVWD_RS_HOLD;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_state <= SVWD_RS_HOLD;
      end else begin
         rst_state <= next_rst_state;
      end
   end

   // Pulse length counted in timebase ticks, reloaded while held
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_count <= RESET_PULSE_MS;
      end else if (next_rst_state == SVWD_RS_HOLD) begin
         rst_count <= RESET_PULSE_MS;
      end else if (rst_state == SVWD_RS_TIMING && tick) begin
         rst_count <= rst_count - 8'h01;
      end
   end

   // Both reset outputs flop from one next state: one edge after the cause
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reset_n_o <= 1'b0;
         reset_o <= HAS_COMPLEMENT;
      end else begin
         reset_n_o <= (next_rst_state == SVWD_RS_RUN);
         reset_o <= HAS_COMPLEMENT && (next_rst_state != SVWD_RS_RUN);
      end
   end

   assign wd_enable = !HAS_COMPLEMENT;
   assign kick_edge = watchdog_kick_in_i != kick_prev;
   assign wd_clear = !wd_enable || rst_state != SVWD_RS_RUN
                     || watchdog_kick_float_i || kick_edge;
   assign wd_expired = wd_count == WD_TIMEOUT_MS;

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         kick_prev <= 1'b0;
      end else begin
         kick_prev <= watchdog_kick_in_i;
      end
   end

   // Count saturates at the timeout, so expiry holds until cleared
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wd_count <= '0;
      end else if (wd_clear) begin
         wd_count <= '0;
      end else if (tick && !wd_expired) begin
         wd_count <= wd_count + 11'h001;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         watchdog_expired_n_o <= 1'b1;
      end else begin
         watchdog_expired_n_o <= !(wd_enable && (wd_expired || supply_low_i));
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         power_fail_warning_n_o <= 1'b1;
      end else begin
         power_fail_warning_n_o <= !power_fail_sense_in_low_i;
      end
   end
endmodule

/* tb/svwd_properties.sv */
`timescale 1ns/1ps
module svwd_checker
   import svwd_pkg::*;
#(parameter bit HAS_COMPLEMENT = 1'b0, parameter int unsigned TICK_CYCLES = 4) (
   input wire logic clk_i, reset_n_i, supply_low_i, manual_reset_button_n_i,
   input wire logic manual_reset_float_i, watchdog_kick_in_i, watchdog_kick_float_i,
   input wire logic power_fail_sense_in_low_i, reset_n_o, reset_o, watchdog_expired_n_o,
   input wire logic power_fail_warning_n_o
);
   localparam int unsigned T = TICK_CYCLES;
   logic hold, kick_q;
   int unsigned pcnt, wcnt;
   assign hold = supply_low_i | (!manual_reset_button_n_i & !manual_reset_float_i);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   always_ff @(posedge clk_i) kick_q <= watchdog_kick_in_i;
   // Cycles since the last reset cause went away
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i) pcnt <= 0;
      else if (hold) pcnt <= 0;
      else if (pcnt < 300 * T) pcnt <= pcnt + 1;
   // Cycles since the last watchdog clear
   always_ff @(posedge clk_i or negedge reset_n_i)
      if (!reset_n_i) wcnt <= 0;
      else if (watchdog_kick_in_i != kick_q || watchdog_kick_float_i || hold || !reset_n_o)
         wcnt <= 0;
      else if (wcnt < 2000 * T) wcnt <= wcnt + 1;
   manual_low_a: assert property (
      !manual_reset_button_n_i && !manual_reset_float_i |=> !reset_n_o) else $error("no reset");
   supply_hold_a: assert property (supply_low_i |=> !reset_n_o) else $error("no hold");
   pulse_hold_a: assert property (
      pcnt < (RESET_PULSE_MS - 1) * T - 1 |-> !reset_n_o) else $error("pulse short");
   pulse_end_a: assert property (
      $rose(reset_n_o) |-> pcnt >= (RESET_PULSE_MS - 1) * T - 1 && pcnt <= RESET_PULSE_MS * T + 4)
      else $error("pulse length");
   complement_a: assert property (
      $past(reset_n_i) |-> reset_o == (HAS_COMPLEMENT ? !reset_n_o : 1'b0)) else $error("compl");
   power_fail_a: assert property (
      $past(reset_n_i) |-> power_fail_warning_n_o == !$past(power_fail_sense_in_low_i))
      else $error("power fail");
   wd_quiet_a: assert property (
      HAS_COMPLEMENT || wcnt > 2 && wcnt < (WD_TIMEOUT_MS - 1) * T - 2 |-> watchdog_expired_n_o)
      else $error("early expiry");
   wd_expire_a: assert property (
      !HAS_COMPLEMENT && wcnt > WD_TIMEOUT_MS * T + 3 |-> !watchdog_expired_n_o)
      else $error("no expiry");
   low_line_a: assert property (
      !HAS_COMPLEMENT && supply_low_i |=> !watchdog_expired_n_o) else $error("no low line");
   wd_no_reset_a: assert property (
      $fell(watchdog_expired_n_o) && reset_n_o && !hold |=> reset_n_o) else $error("wd reset");
endmodule
bind svwd_top svwd_checker #(.HAS_COMPLEMENT(HAS_COMPLEMENT), .TICK_CYCLES(TICK_CYCLES)) chk (
   .clk_i(clk_i), .reset_n_i(reset_n_i), .supply_low_i(supply_low_i),
   .manual_reset_button_n_i(manual_reset_button_n_i), .manual_reset_float_i(manual_reset_float_i),
   .watchdog_kick_in_i(watchdog_kick_in_i), .watchdog_kick_float_i(watchdog_kick_float_i),
   .power_fail_sense_in_low_i(power_fail_sense_in_low_i), .reset_n_o(reset_n_o),
   .reset_o(reset_o), .watchdog_expired_n_o(watchdog_expired_n_o),
   .power_fail_warning_n_o(power_fail_warning_n_o));

/* tb/svwd_host.sv */
`timescale 1ns/1ps
module svwd_host (
   input wire logic clk_i,    // System clock
   input wire logic run_i,    // Software alive and kicking
   input wire logic float_i,  // Kick driver tri-stated
   output logic kick_o        // Kick line
);
   int unsigned gap = 1;
   logic float_q = 1'b0;
   initial kick_o = 1'b0;
   always @(posedge clk_i) begin
      #1;
      if (float_i && !float_q) kick_o = ~kick_o; // Released line settles once, then rests
      else if (!float_i && run_i && --gap == 0) begin
         kick_o = ~kick_o; // Each level held whole cycles
         gap = 1 + $urandom % 40;
      end
      float_q = float_i;
   end
endmodule

/* tb/svwd_top_tb.sv */
`timescale 1ns/1ps
module svwd_top_tb;
   import svwd_pkg::*;
   localparam int unsigned T = 4;
   logic clk_i = 0, reset_n_i = 0, supply_low_i = 0, manual_reset_button_n_i = 1;
   logic manual_reset_float_i = 0, watchdog_kick_float_i = 0, power_fail_sense_in_low_i = 0;
   logic run = 0, watchdog_kick_in_i, rst_n, rst, wd_n, pf_n, rst_n2, rst2, wd_n2;
   int failures = 0, total_checks = 0, n;
   always #25 clk_i = ~clk_i;
   svwd_top #(.TICK_CYCLES(T)) DUT (.clk_i, .reset_n_i, .supply_low_i, .manual_reset_button_n_i,
      .manual_reset_float_i, .watchdog_kick_in_i, .watchdog_kick_float_i,
      .power_fail_sense_in_low_i, .reset_n_o(rst_n), .reset_o(rst), .watchdog_expired_n_o(wd_n),
      .power_fail_warning_n_o(pf_n));
   svwd_top #(.HAS_COMPLEMENT(1'b1), .TICK_CYCLES(T)) DUT2 (.clk_i, .reset_n_i, .supply_low_i,
      .manual_reset_button_n_i, .manual_reset_float_i, .watchdog_kick_in_i,
      .watchdog_kick_float_i, .power_fail_sense_in_low_i, .reset_n_o(rst_n2), .reset_o(rst2),
      .watchdog_expired_n_o(wd_n2), .power_fail_warning_n_o());
   svwd_host host (.clk_i, .run_i(run), .float_i(watchdog_kick_float_i),
      .kick_o(watchdog_kick_in_i));
   task automatic step(input int k);
      repeat (k) @(posedge clk_i);
      #1;
   endtask
   task automatic check(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %0t level %b expected %b", $time, got, exp);
      end
   endtask
   task automatic check_len(input int got, input int lo, input int hi);
      total_checks++;
      if (got < lo || got > hi) begin
         failures++;
         $display("MISMATCH %0t length %0d outside %0d..%0d", $time, got, lo, hi);
      end
   endtask
   task automatic wait_wd(input logic lvl, input int lim);
      n = 0;
      while (wd_n !== lvl && n < lim) begin
         step(1);
         n++;
      end
   endtask
   task automatic pulse;
      n = 0;
      while (rst_n !== 1'b1 && n < 300 * T) begin
         step(1);
         n++;
      end
      check_len(n, (RESET_PULSE_MS - 1) * T - 1, RESET_PULSE_MS * T + 4);
      check(rst2, ~rst_n2);
      check(rst, 1'b0);
   endtask
   task automatic finish_test;
      if (failures == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      void'($urandom(32'h5083));
      step(19);
      check(rst2, ~rst_n2);
      step(1);
      reset_n_i = 1;
      step(1);
      check(rst2, 1'b1);
      pulse();
      run = 1;
      manual_reset_button_n_i = 0;
      manual_reset_float_i = 1;
      step(3);
      check(rst_n, 1'b1);
      manual_reset_float_i = 0;
      step(1);
      check(rst_n, 1'b0);
      step(9);
      manual_reset_button_n_i = 1;
      pulse();
      repeat (2) begin
         supply_low_i = 1;
         step(1 + $urandom % 50);
         check(rst_n, 1'b0);
         check(wd_n, 1'b0);
         check(wd_n2, 1'b1);
         supply_low_i = 0;
         step(1);
         check(wd_n, 1'b1);
         pulse();
      end
      run = 0;
      wait_wd(1'b0, 1700 * T);
      check_len(n, (WD_TIMEOUT_MS - 1) * T - 42, WD_TIMEOUT_MS * T + 4);
      step(200);
      check(wd_n, 1'b0);
      check(rst_n, 1'b1);
      run = 1;
      wait_wd(1'b1, 50);
      check(wd_n, 1'b1);
      watchdog_kick_float_i = 1;
      step(1700 * T);
      check(wd_n, 1'b1);
      watchdog_kick_float_i = 0;
      repeat (40) begin
         power_fail_sense_in_low_i = 1'($urandom);
         step(1);
         check(pf_n, ~power_fail_sense_in_low_i);
      end
      finish_test();
   end
   initial begin
      repeat (30000) @(posedge clk_i);
      failures++;
      finish_test();
   end
endmodule
